// file: rtl/iep_pkg.sv
// package: register map, field layout and timing constants of the block
package iep_pkg;
    localparam logic [7:0] iep_off_enables = 8'h68;
    localparam logic [7:0] iep_off_delay = 8'h6c;
    localparam logic [7:0] iep_off_level = 8'h70;
    localparam logic [7:0] iep_off_int_status = 8'h80;
    localparam logic [7:0] iep_off_int_mask = 8'h84;
    localparam int iep_always_bit = 31;
    localparam int iep_event_bits = 20;
    localparam int iep_rdlvl_lsb = 16;
    localparam int iep_lvl_w = 14;
    localparam logic [31:0] iep_enables_reset = 32'h0000_0000;
    localparam logic [31:0] iep_enables_mask = 32'h800f_ffff;
    localparam logic [15:0] iep_delay_reset = 16'h0800;
    // one delay unit is 16.667 ns; at 10 ns per clock count in picoseconds
    localparam int iep_unit_ps = 16667;
    localparam int iep_clk_ps = 10000;
    localparam int iep_irq_bits = 3;

    typedef struct packed {
        logic always_report_enable;
        logic mac_reset_timeout_enable;
        logic rx_frame_enable;
        logic transmitter_stopped_enable;
        logic receiver_stopped_enable;
        logic phy_event_enable;
        logic transmit_error_enable;
        logic tx_underrun_enable;
        logic tx_overrun_enable;
        logic rx_dropped_frame_enable;
        logic [10:0] pin_event_enables;
    } iep_enables_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } iep_bus_t;

    typedef struct packed {
        logic wr_dword;
        logic wr_done;
        logic wr_rewind;
        logic rd_dword;
        logic rd_done;
        logic rd_rewind;
    } iep_fifo_ev_t;
endpackage

// file: rtl/iep_regs.sv
// interrupt endpoint reporting, short-packet delay and rx fifo levels
`timescale 1ns/100ps
module iep_regs (
    input wire logic clk,
    input wire logic rst,
    input wire iep_pkg::iep_bus_t bus,
    output logic [31:0] rdata,
    input wire logic [19:0] events,
    input wire logic poll_tick,
    output logic status_send,
    output logic [19:0] status_bits,
    input wire logic short_pkt_req,
    output logic short_pkt_go,
    input wire iep_pkg::iep_fifo_ev_t fifo_ev,
    output logic [13:0] rx_read_level,
    output logic [13:0] rx_write_level,
    output logic irq
);
    iep_pkg::iep_enables_t enables;
    logic [15:0] short_packet_delay;
    logic [19:0] pending;
    logic [13:0] wr_pkt_cnt;
    logic [13:0] rd_pkt_cnt;
    logic [13:0] done_q [0:15];
    logic [3:0] q_head;
    logic [3:0] q_tail;
    logic [13:0] head_cnt;
    logic [31:0] dly_acc;
    logic waiting;
    logic [iep_pkg::iep_irq_bits-1:0] int_status;
    logic [iep_pkg::iep_irq_bits-1:0] int_mask;
    logic [19:0] gated;
    logic send_now;
    logic [iep_pkg::iep_irq_bits-1:0] irq_ev;

    function automatic logic hit(input iep_pkg::iep_bus_t b,
                                 input logic [7:0] off);
        hit = b.wr && (b.addr == off);
    endfunction

    assign gated = events & 20'(enables);
    // all twenty event enables, bits 19:0, gate by bit position
    assign send_now = poll_tick &&
        (enables.always_report_enable || (pending != 20'h0));
    assign head_cnt = done_q[q_head];
    assign irq_ev = {short_pkt_go, fifo_ev.wr_rewind, send_now};

    always_ff @(posedge clk) begin
        if (rst) begin
            enables <= iep_pkg::iep_enables_t'(iep_pkg::iep_enables_reset);
        end else if (hit(bus, iep_pkg::iep_off_enables)) begin
            enables <= iep_pkg::iep_enables_t'({bus.wdata[31],
                                                bus.wdata[19:0]});
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            short_packet_delay <= iep_pkg::iep_delay_reset;
        end else if (hit(bus, iep_pkg::iep_off_delay)) begin
            short_packet_delay <= bus.wdata[15:0];
        end
    end

    // pending events latch until reported; a new event beats the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            pending <= 20'h0;
            status_send <= 1'b0;
            status_bits <= 20'h0;
        end else begin
            status_send <= send_now;
            if (send_now) begin
                status_bits <= pending | gated;
                pending <= gated;
            end else begin
                pending <= pending | gated;
            end
        end
    end

    // delay accumulates in picoseconds so 16.667 ns units stay exact
    always_ff @(posedge clk) begin
        if (rst) begin
            waiting <= 1'b0;
            dly_acc <= 32'h0;
            short_pkt_go <= 1'b0;
        end else begin
            short_pkt_go <= 1'b0;
            if (!waiting && short_pkt_req) begin
                waiting <= 1'b1;
                dly_acc <= 32'h0;
            end else if (waiting) begin
                if (dly_acc >= 32'(short_packet_delay) *
                        32'(iep_pkg::iep_unit_ps)) begin
                    waiting <= 1'b0;
                    short_pkt_go <= 1'b1;
                end else begin
                    dly_acc <= dly_acc + 32'(iep_pkg::iep_clk_ps);
                end
            end
        end
    end

    // write side: count dwords of the packet being stored
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pkt_cnt <= 14'h0;
            q_tail <= 4'h0;
        end else if (fifo_ev.wr_rewind) begin
            wr_pkt_cnt <= 14'h0;
        end else if (fifo_ev.wr_done) begin
            done_q[q_tail] <= wr_pkt_cnt + 14'(fifo_ev.wr_dword);
            q_tail <= q_tail + 4'h1;
            wr_pkt_cnt <= 14'h0;
        end else if (fifo_ev.wr_dword) begin
            wr_pkt_cnt <= wr_pkt_cnt + 14'h1;
        end
    end

    // read side: limitation, at most 16 complete packets are tracked
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pkt_cnt <= 14'h0;
            q_head <= 4'h0;
        end else if (fifo_ev.rd_rewind) begin
            rd_pkt_cnt <= 14'h0;
        end else if (fifo_ev.rd_done) begin
            rd_pkt_cnt <= 14'h0;
            q_head <= q_head + 4'h1;
        end else if (fifo_ev.rd_dword) begin
            rd_pkt_cnt <= rd_pkt_cnt + 14'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_write_level <= 14'h0;
        end else begin
            rx_write_level <= rx_write_level
                + (fifo_ev.wr_dword ? 14'h1 : 14'h0)
                - (fifo_ev.wr_rewind ? wr_pkt_cnt : 14'h0)
                - (fifo_ev.rd_done ? head_cnt : 14'h0);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_read_level <= 14'h0;
        end else begin
            rx_read_level <= rx_read_level
                + (fifo_ev.wr_done ?
                   wr_pkt_cnt + 14'(fifo_ev.wr_dword) : 14'h0)
                - ((fifo_ev.rd_dword && !fifo_ev.rd_rewind) ?
                   14'h1 : 14'h0)
                + (fifo_ev.rd_rewind ? rd_pkt_cnt : 14'h0);
        end
    end

    // sticky interrupt status: set wins over a write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            int_status <= '0;
        end else if (hit(bus, iep_pkg::iep_off_int_status)) begin
            int_status <= (int_status &
                ~bus.wdata[iep_pkg::iep_irq_bits-1:0]) | irq_ev;
        end else begin
            int_status <= int_status | irq_ev;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            int_mask <= '0;
        end else if (hit(bus, iep_pkg::iep_off_int_mask)) begin
            int_mask <= bus.wdata[iep_pkg::iep_irq_bits-1:0];
        end
    end

    // a set mask bit hides its status bit; reset leaves all unmasked
    assign irq = |(int_status & ~int_mask);

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (bus.rd) begin
            unique case (bus.addr)
                iep_pkg::iep_off_enables:
                    rdata <= {enables.always_report_enable, 11'h0,
                              enables[19:0]};
                iep_pkg::iep_off_delay: rdata <= {16'h0, short_packet_delay};
                iep_pkg::iep_off_level:
                    rdata <= {2'h0, rx_read_level, 2'h0, rx_write_level};
                iep_pkg::iep_off_int_status: rdata <= {29'h0, int_status};
                iep_pkg::iep_off_int_mask: rdata <= {29'h0, int_mask};
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end
endmodule

// file: bench/iep_regs_props.sv
// checker for the interrupt endpoint register block ports
`timescale 1ns/100ps
module iep_regs_props (
    input wire logic clk,
    input wire logic rst,
    input wire iep_pkg::iep_bus_t bus,
    input wire logic [31:0] rdata,
    input wire logic poll_tick,
    input wire logic status_send,
    input wire logic [19:0] status_bits,
    input wire logic short_pkt_req,
    input wire logic short_pkt_go,
    input wire iep_pkg::iep_fifo_ev_t fifo_ev,
    input wire logic [13:0] rx_read_level,
    input wire logic [13:0] rx_write_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_poll_send;
        poll_tick ##1 status_send;
    endsequence
    c_poll_send: cover property (s_poll_send);
    a_send_needs_tick: assert property (
        status_send |-> $past(poll_tick)) else $error("send without poll");
    a_bits_hold: assert property (
        !status_send |-> $stable(status_bits)) else $error("bits moved");
    a_rdata_idle: assert property (
        !$past(bus.rd) |-> rdata == '0) else $error("stray read data");
    a_go_delayed: assert property (
        short_pkt_go |-> !$past(short_pkt_req)) else $error("go too soon");
    a_go_single: assert property (
        short_pkt_go |=> !short_pkt_go) else $error("go too long");
    a_wr_inc: assert property (
        fifo_ev == 6'h20 |=> rx_write_level == $past(rx_write_level) + 14'h1)
        else $error("write level step");
    a_rd_dec: assert property (
        fifo_ev == 6'h04 |=> rx_read_level == $past(rx_read_level) - 14'h1)
        else $error("read level step");
    a_lvl_quiet: assert property (
        fifo_ev == '0 |=> $stable(rx_read_level) && $stable(rx_write_level))
        else $error("level moved");
endmodule
bind iep_regs iep_regs_props i_props (.clk, .rst, .bus, .rdata,
    .poll_tick, .status_send, .status_bits, .short_pkt_req,
    .short_pkt_go, .fifo_ev, .rx_read_level, .rx_write_level);

// file: bench/iep_host_model.sv
// host side: polls the interrupt endpoint every 16 cycles
`timescale 1ns/100ps
module iep_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic status_send,
    input wire logic [19:0] status_bits,
    output logic poll_tick,
    output logic [7:0] sends,
    output logic [19:0] last
);
    logic [3:0] phase;
    always_ff @(posedge clk) begin
        phase <= rst ? 4'h0 : phase + 4'h1;
        poll_tick <= !rst && phase == 4'hf;
        sends <= rst ? 8'h0 : sends + 8'(status_send);
        if (status_send) begin
            last <= status_bits;
        end
    end
endmodule

// file: bench/iep_regs_test.sv
// self-checking bench for the interrupt endpoint register block
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module iep_regs_test;
    logic clk, rst, poll_tick, status_send, req, go, irq, a;
    iep_pkg::iep_bus_t bus;
    iep_pkg::iep_fifo_ev_t fifo_ev;
    logic [31:0] rdata, e, seed;
    logic [19:0] events, status_bits, v, last;
    logic [13:0] rl, wl;
    logic [7:0] sends, n0;
    int errors, num_checks, n, k;
    iep_regs i_dut (.clk, .rst, .bus, .rdata, .events, .poll_tick,
        .status_send, .status_bits, .short_pkt_req(req),
        .short_pkt_go(go), .fifo_ev, .rx_read_level(rl),
        .rx_write_level(wl), .irq);
    iep_host_model i_host (.clk, .rst, .status_send, .status_bits,
        .poll_tick, .sends, .last);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lvl(logic [13:0] r, logic [13:0] w);
        return {2'b0, r, 2'b0, w};
    endfunction
    // delay counted in picoseconds, rounded up, plus the launch cycle
    function automatic int dly(int d);
        return (d * 16667 + 9999) / 10000 + 1;
    endfunction
    task automatic tally_and_finish;
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(logic [7:0] ad, logic [31:0] d);
        @(posedge clk) bus <= '{1'b1, 1'b0, ad, d};
        @(posedge clk) bus <= '0;
    endtask
    task automatic rd(logic [7:0] ad, logic [31:0] x);
        @(posedge clk) bus <= '{1'b0, 1'b1, ad, 32'h0};
        @(posedge clk) bus <= '0;
        #1 `CHK(rdata, x)
    endtask
    task automatic fe(logic [5:0] f, int m);
        repeat (m) @(posedge clk) fifo_ev <= f;
        @(posedge clk) fifo_ev <= '0;
    endtask
    initial begin
        seed = 32'hdc7bccb8;
        rst = 1;
        bus = '0;
        events = '0;
        req = 0;
        fifo_ev = '0;
        repeat (12) @(posedge clk);
        rst <= 0;
        rd(8'h68, 32'h0);
        rd(8'h6c, 32'h800);
        rd(8'h70, 32'h0);
        rd(8'h7c, 32'h0);
        for (int i = 0; i < 10; i++) begin
            e = i == 0 ? 32'h0 : 32'hffffffff;
            v = 20'hfffff;
            if (i > 1) e = $random(seed);
            if (i > 1) v = $random(seed);
            wr(8'h68, e & 32'h000fffff);
            rd(8'h68, e & 32'h000fffff);
            n = 0;
            // line the event up clear of the send cycle
            while (n < 40 && poll_tick !== 1'b1) begin
                @(posedge clk);
                n++;
                #1;
            end
            if (n == 40) errors++;
            if (n == 40) tally_and_finish();
            @(posedge clk) events <= v;
            @(posedge clk) events <= '0;
            n0 = sends;
            repeat (20) @(posedge clk);
            #1;
            `CHK(sends != n0, (v & e[19:0]) != 0)
            if (sends != n0) `CHK(last, v & e[19:0])
        end
        wr(8'h68, 32'h80000000);
        n0 = sends;
        repeat (40) @(posedge clk);
        `CHK(sends - n0 > 1, 1'b1)
        `CHK(last, 20'h0)
        wr(8'h68, 32'h0);
        k = 1 + $unsigned($random(seed)) % 8;
        fe(6'h20, k);
        fe(6'h10, 1);
        rd(8'h70, lvl(14'(k), 14'(k)));
        fe(6'h04, k / 2);
        rd(8'h70, lvl(14'(k - k / 2), 14'(k)));
        fe(6'h01, 1);
        rd(8'h70, lvl(14'(k), 14'(k)));
        fe(6'h04, k);
        fe(6'h02, 1);
        rd(8'h70, lvl(14'h0, 14'h0));
        fe(6'h20, 3);
        fe(6'h08, 1);
        rd(8'h70, lvl(14'h0, 14'h0));
        for (int d = 1; d < 8; d += 3) begin
            wr(8'h6c, 32'(d));
            rd(8'h6c, 32'(d));
            @(posedge clk) req <= 1;
            @(posedge clk) req <= 0;
            n = 0;
            #1;
            while (n < 60 && go !== 1'b1) begin
                @(posedge clk);
                n++;
                #1;
            end
            `CHK(n, dly(d))
        end
        rd(8'h80, 32'h7);
        wr(8'h84, 32'h0);
        #1 `CHK(irq, 1'b1)
        wr(8'h84, 32'h7);
        #1 `CHK(irq, 1'b0)
        wr(8'h80, 32'h7);
        rd(8'h80, 32'h0);
        wr(8'h84, 32'h0);
        #1 `CHK(irq, 1'b0)
        tally_and_finish();
    end
endmodule
